// ==== logic/ilpc_ctrl.sv ====
// interrupt latches, enables, acceptance sequence and special-function access
`timescale 1ns/1ps
module ilpc_ctrl
  import ilpc_pkg::*;
(
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  // special-function access
  input  wire ilpc_pkg::ilpc_sfr_req_t sfr_req,
  output logic [7:0]                 sfr_rdata,
  // hardware requests, one-cycle pulses
  input  wire logic                  trap_req,
  input  wire logic                  wdog_req,
  input  wire logic [19:0]           maskable_req,
  // software and bad-opcode requests, held at the boundary
  input  wire logic                  software_trap_source,
  input  wire logic                  bad_opcode_source,
  // loose control bits
  input  wire logic                  ext_pin_zero_gate,
  input  wire logic                  trap_output_select,
  input  wire logic                  watchdog_output_select,
  // cpu sequencer
  input  wire logic                  instr_boundary,
  input  wire logic [15:0]           cpu_pc,
  input  wire logic [7:0]            cpu_psw,
  input  wire logic [15:0]           cpu_sp,
  input  wire logic                  reti_strobe,
  input  wire logic                  reti_gie,
  // acceptance results
  output logic                       irq_pending,
  output logic                       acc_busy,
  output logic                       acc_done,
  output logic [15:0]                acc_vector,
  output logic [15:0]                acc_sp,
  output ilpc_pkg::ilpc_stk_t        stk,
  // reset requests from trap and watchdog
  output logic                       trap_reset_req,
  output logic                       wdog_reset_req
);
  import ilpc_pkg::*;

  // acceptance sequence states
  typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_WAIT} ilpc_state_t;

  // whole module state
  typedef struct packed {
    ilpc_state_t st;
    logic [23:0] pending_latch;     // bits 1:0 never set
    logic [23:0] source_enable_flag;
    logic        global_irq_enable;
    logic        saved_gie;         // enable value before acceptance
    logic [4:0]  acc_idx;
    logic [5:0]  cnt;               // clocks since acceptance
    logic [1:0]  push_step;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0]  psw;
    logic [15:0] vector;
    logic        done;
    ilpc_stk_t   stk;
    logic [7:0]  rdata;
    logic        trap_rst;
    logic        wdog_rst;
  } ilpc_ctrl_state_t;

  ilpc_ctrl_state_t s;              // registered state
  ilpc_ctrl_state_t next_s;         // next state

  logic [23:0] hw_set;              // latch set requests this cycle
  logic [23:0] eligible;            // latches allowed to win
  logic        win_valid;
  logic [4:0]  win_idx;
  logic [15:0] win_vec;
  logic        accept;              // acceptance starts this cycle

  // byte of a latch or enable group for reads
  function automatic logic [7:0] grp_byte(input logic [23:0] v, input logic [7:0] a);
    logic [7:0] b;
    b = 8'h00;
    if (a == ILPC_ADDR_LATCH_LOW || a == ILPC_ADDR_EN_LOW)
      b = v[7:0];
    else if (a == ILPC_ADDR_LATCH_MID || a == ILPC_ADDR_EN_MID)
      b = v[15:8];
    else if (a == ILPC_ADDR_LATCH_HIGH || a == ILPC_ADDR_EN_HIGH)
      b = v[23:16];
    return b;
  endfunction : grp_byte

  // hardware sets; trap and watchdog only latch when routed to interrupt
  always_comb
  begin
    hw_set                 = {maskable_req, 4'h0};
    hw_set[ILPC_TRAP_IDX]  = trap_req & ~trap_output_select;
    hw_set[ILPC_WDOG_IDX]  = wdog_req & ~watchdog_output_select;
  end

  // who may be accepted now
  always_comb
  begin
    eligible = s.pending_latch & s.source_enable_flag & {24{s.global_irq_enable}};
    eligible[ILPC_EXT0_IDX] = eligible[ILPC_EXT0_IDX] & ext_pin_zero_gate;
    eligible[ILPC_TRAP_IDX] = s.pending_latch[ILPC_TRAP_IDX];
    eligible[ILPC_WDOG_IDX] = s.pending_latch[ILPC_WDOG_IDX];
    eligible[1:0]           = 2'b00;
  end

  // priority and vector choice
  ilpc_prio_sel u_sel (
    .soft_req  (software_trap_source | bad_opcode_source),
    .eligible  (eligible),
    .win_valid (win_valid),
    .win_idx   (win_idx),
    .win_vec   (win_vec)
  );

  assign accept = instr_boundary && (s.st == ST_IDLE) && win_valid;

  // next-state logic
  always_comb
  begin
    logic [23:0] clr;               // software clears
    logic [23:0] acc_clr;           // acceptance clear
    logic [23:0] set_eff;           // sets that survive
    clr     = 24'h000000;
    acc_clr = 24'h000000;
    set_eff = hw_set;
    next_s  = s;
    next_s.done     = 1'b0;
    next_s.stk.we   = 1'b0;
    next_s.trap_rst = trap_req & trap_output_select;
    next_s.wdog_rst = wdog_req & watchdog_output_select;

    // register reads, data one cycle later
    if (sfr_req.rd)
    begin
      if (sfr_req.addr == ILPC_ADDR_LATCH_LOW)
        next_s.rdata = {s.pending_latch[7:2], 2'b00};
      else if (sfr_req.addr == ILPC_ADDR_LATCH_MID || sfr_req.addr == ILPC_ADDR_LATCH_HIGH)
        next_s.rdata = grp_byte(s.pending_latch, sfr_req.addr);
      else if (sfr_req.addr == ILPC_ADDR_EN_LOW)
        next_s.rdata = {s.source_enable_flag[7:4], 3'h0, s.global_irq_enable};
      else if (sfr_req.addr == ILPC_ADDR_EN_MID || sfr_req.addr == ILPC_ADDR_EN_HIGH)
        next_s.rdata = grp_byte(s.source_enable_flag, sfr_req.addr);
      else
        next_s.rdata = 8'h00;                                        // unmapped reads zero
    end

    // register writes: latch bytes only clear, never set
    if (sfr_req.wr)
    begin
      if (sfr_req.addr == ILPC_ADDR_LATCH_LOW)
        clr[7:2] = ~sfr_req.wdata[7:2];
      else if (sfr_req.addr == ILPC_ADDR_LATCH_MID)
        clr[15:8] = ~sfr_req.wdata;
      else if (sfr_req.addr == ILPC_ADDR_LATCH_HIGH)
        clr[23:16] = ~sfr_req.wdata;
      else if (sfr_req.addr == ILPC_ADDR_EN_LOW)
      begin
        next_s.global_irq_enable       = sfr_req.wdata[ILPC_GIE_BIT];
        next_s.source_enable_flag[7:4] = sfr_req.wdata[7:4];
      end
      else if (sfr_req.addr == ILPC_ADDR_EN_MID)
        next_s.source_enable_flag[15:8] = sfr_req.wdata;
      else if (sfr_req.addr == ILPC_ADDR_EN_HIGH)
        next_s.source_enable_flag[23:16] = sfr_req.wdata;
    end

    // return from interrupt restores the stacked enable
    if (reti_strobe)
      next_s.global_irq_enable = reti_gie;

    // acceptance start
    if (accept)
    begin
      next_s.saved_gie         = s.global_irq_enable;
      next_s.global_irq_enable = 1'b0;                               // wins over a same-cycle write
      next_s.acc_idx           = win_idx;
      next_s.vector            = win_vec;
      next_s.sp                = cpu_sp;
      next_s.pc                = cpu_pc;
      next_s.psw               = cpu_psw;
      next_s.cnt               = 6'h01;
      next_s.push_step         = 2'h0;
      next_s.st                = ST_PUSH;
      if (win_idx != 5'(ILPC_SWI_IDX))
        acc_clr[win_idx] = 1'b1;
      // a converter request landing while a lower source is taken is lost
      if (win_idx > 5'(ILPC_CONV_IDX))
        set_eff[ILPC_CONV_IDX] = 1'b0;
    end

    // latch update: hardware set wins over a software clear
    next_s.pending_latch = (s.pending_latch & ~clr & ~acc_clr) | set_eff;
    next_s.pending_latch[1:0] = 2'b00;

    // acceptance sequence
    case (s.st)
      ST_IDLE:
      begin
      end
      ST_PUSH:
      begin
        next_s.cnt      = s.cnt + 6'h01;
        next_s.stk.we   = 1'b1;
        next_s.stk.addr = s.sp;
        next_s.sp       = s.sp - 16'h0001;
        if (s.push_step == 2'h0)
          next_s.stk.data = {s.psw[7:1], s.saved_gie};
        else if (s.push_step == 2'h1)
          next_s.stk.data = s.pc[15:8];
        else
          next_s.stk.data = s.pc[7:0];
        next_s.push_step = s.push_step + 2'h1;
        if (s.push_step == ILPC_PUSH_LAST)
          next_s.st = ST_WAIT;
      end
      ST_WAIT:
      begin
        next_s.cnt = s.cnt + 6'h01;
        if (s.cnt == ILPC_ACCEPT_CLKS - 6'h01)
        begin
          next_s.done = 1'b1;
          next_s.st   = ST_IDLE;
        end
      end
      default:
        next_s.st = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s                    <= '0;
      s.st                 <= ST_IDLE;
      s.pending_latch      <= ILPC_LATCH_RST;
      s.source_enable_flag <= ILPC_EN_RST;
      s.global_irq_enable  <= ILPC_GIE_RST;
      s.vector             <= ILPC_VEC_RESET;
    end
    else
      s <= next_s;
  end

  // outputs
  assign sfr_rdata      = s.rdata;
  assign irq_pending    = win_valid && (s.st == ST_IDLE);
  assign acc_busy       = (s.st != ST_IDLE);
  assign acc_done       = s.done;
  assign acc_vector     = s.vector;
  assign acc_sp         = s.sp;
  assign stk            = s.stk;
  assign trap_reset_req = s.trap_rst;
  assign wdog_reset_req = s.wdog_rst;

endmodule : ilpc_ctrl

// ==== logic/ilpc_pkg.sv ====
// package for the interrupt latch and priority controller: constants, types, vector map
// Function
// - 24 sources, four non-maskable, rest maskable
// - hardware request sets its pending latch
// - maskable needs global and source enable
// - pin source zero also needs pin gate
// - fixed priority, pin zero highest maskable
// - non-maskable sources share one level
// - non-maskable vectors fffc, fffa, fff8, fffe
// - maskable vectors fff6..ffe0 and ffbe..ffb0
// - latches for all but software, bad-opcode
// - accepted source latch cleared at once
// - all latches zero after reset
// - writing zero clears; latches at 2e,3c,3d
// - writing one never sets a latch
// - latch reads show pending state
// - trap is reset unless select cleared
// - watchdog is reset unless select cleared
// - converter request may drop during lower acceptance
// - acceptance takes 8 machine cycles
// - push status, pc high, pc low; sp minus 3
// - global enable bit 0 at 3a, reset zero
package ilpc_pkg;

  // source numbering and counts
  localparam int ILPC_NSRC      = 24;
  localparam int ILPC_SWI_IDX   = 0;          // shared software / bad-opcode slot, no latch
  localparam int ILPC_TRAP_IDX  = 2;
  localparam int ILPC_WDOG_IDX  = 3;
  localparam int ILPC_EXT0_IDX  = 4;
  localparam int ILPC_CONV_IDX  = 15;
  localparam int ILPC_HIGH_IDX  = 16;         // first source of the upper vector block
  localparam int ILPC_NMASK     = 20;         // maskable sources 4..23

  // special-function addresses
  localparam logic [7:0] ILPC_ADDR_LATCH_HIGH = 8'h2e;
  localparam logic [7:0] ILPC_ADDR_LATCH_LOW  = 8'h3c;
  localparam logic [7:0] ILPC_ADDR_LATCH_MID  = 8'h3d;
  localparam logic [7:0] ILPC_ADDR_EN_HIGH    = 8'h2c;
  localparam logic [7:0] ILPC_ADDR_EN_LOW     = 8'h3a;
  localparam logic [7:0] ILPC_ADDR_EN_MID     = 8'h3b;
  localparam int         ILPC_GIE_BIT         = 0;

  // reset values
  localparam logic [23:0] ILPC_LATCH_RST = 24'h000000;
  localparam logic [23:0] ILPC_EN_RST    = 24'h000000;
  localparam logic        ILPC_GIE_RST   = 1'b0;

  // vectors
  localparam logic [15:0] ILPC_VEC_RESET    = 16'hfffe;
  localparam logic [15:0] ILPC_VEC_SWI      = 16'hfffc;
  localparam logic [15:0] ILPC_VEC_TRAP     = 16'hfffa;
  localparam logic [15:0] ILPC_VEC_WDOG     = 16'hfff8;
  localparam logic [15:0] ILPC_VEC_LOW_TOP  = 16'hfff6;
  localparam logic [15:0] ILPC_VEC_HIGH_TOP = 16'hffbe;

  // timing: one machine cycle is four clocks, acceptance is eight machine cycles
  localparam int         ILPC_MCYC_CLKS   = 4;
  localparam int         ILPC_ACCEPT_MCYC = 8;
  localparam logic [5:0] ILPC_ACCEPT_CLKS = 6'(ILPC_ACCEPT_MCYC * ILPC_MCYC_CLKS);
  localparam logic [1:0] ILPC_PUSH_LAST   = 2'h2;

  // special-function access from the cpu
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ilpc_sfr_req_t;

  // one stack byte write toward memory
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  data;
  } ilpc_stk_t;

  // vector address of a source index
  function automatic logic [15:0] ilpc_vector(input logic [4:0] idx);
    logic [15:0] v;
    v = ILPC_VEC_SWI;
    if (idx == 5'(ILPC_TRAP_IDX))
      v = ILPC_VEC_TRAP;
    else if (idx == 5'(ILPC_WDOG_IDX))
      v = ILPC_VEC_WDOG;
    else if (idx >= 5'(ILPC_HIGH_IDX))
      v = ILPC_VEC_HIGH_TOP - {10'h000, idx - 5'(ILPC_HIGH_IDX), 1'b0};
    else if (idx >= 5'(ILPC_EXT0_IDX))
      v = ILPC_VEC_LOW_TOP - {10'h000, idx - 5'(ILPC_EXT0_IDX), 1'b0};
    return v;
  endfunction : ilpc_vector

endpackage : ilpc_pkg

// ==== logic/ilpc_prio_sel.sv ====
// fixed-priority selector: picks the winning source and its vector
`timescale 1ns/1ps
module ilpc_prio_sel
  import ilpc_pkg::*;
(
  // candidates
  input  wire logic        soft_req,
  input  wire logic [23:0] eligible,
  // winner
  output logic             win_valid,
  output logic [4:0]       win_idx,
  output logic [15:0]      win_vec
);

  // non-maskable first, then lowest maskable index
  always_comb
  begin
    win_valid = 1'b0;
    win_idx   = 5'h00;
    if (soft_req)                                     // shared level, taken first here
    begin
      win_valid = 1'b1;
      win_idx   = 5'(ILPC_SWI_IDX);
    end
    else if (eligible[ILPC_TRAP_IDX])
    begin
      win_valid = 1'b1;
      win_idx   = 5'(ILPC_TRAP_IDX);
    end
    else if (eligible[ILPC_WDOG_IDX])
    begin
      win_valid = 1'b1;
      win_idx   = 5'(ILPC_WDOG_IDX);
    end
    else
    begin
      // descending scan so the lowest index wins
      for (int i = ILPC_NSRC - 1; i >= ILPC_EXT0_IDX; i--)
      begin
        if (eligible[i])
        begin
          win_valid = 1'b1;
          win_idx   = 5'(i);
        end
      end
    end
    win_vec = ilpc_vector(win_idx);
  end

endmodule : ilpc_prio_sel

// ==== tb/ilpc_cpu_model.sv ====
// cpu sequencer model: boundary pulses and a fixed context
`timescale 1ns/1ps
module ilpc_cpu_model (
  // clock
  input  wire logic   sys_clk,
  // step request from the bench
  input  wire logic   step,
  // return request from the bench
  input  wire logic   ret,
  // sequencer outputs
  output logic        instr_boundary,
  output logic [15:0] cpu_pc,
  output logic [7:0]  cpu_psw,
  output logic [15:0] cpu_sp,
  output logic        reti_strobe,
  output logic        reti_gie
);
  // one instruction ends, or one return executes, one cycle after each request
  initial
  begin
    {instr_boundary, reti_strobe} = 2'b00;
    forever @(posedge sys_clk) {instr_boundary, reti_strobe} <= {step, ret};
  end
  // context held steady across an acceptance
  assign cpu_pc      = 16'h1234;
  assign cpu_psw     = 8'ha5;
  assign cpu_sp      = 16'h0100;
  // a return always restores an enabled state
  assign reti_gie    = 1'b1;
endmodule : ilpc_cpu_model

// ==== tb/ilpc_ctrl_assertions.sv ====
// port checker for the interrupt latch controller
`timescale 1ns/1ps
module ilpc_ctrl_assertions
  import ilpc_pkg::*;
(
  // clock and reset
  input wire logic                    sys_clk,
  input wire logic                    nrst,
  // bus and requests
  input wire ilpc_pkg::ilpc_sfr_req_t sfr_req,
  input wire logic [7:0]              sfr_rdata,
  input wire logic                    trap_req,
  input wire logic                    wdog_req,
  input wire logic                    software_trap_source,
  input wire logic                    bad_opcode_source,
  input wire logic                    trap_output_select,
  input wire logic                    watchdog_output_select,
  input wire logic                    instr_boundary,
  input wire logic                    irq_pending,
  input wire logic [15:0]             cpu_sp,
  // results
  input wire logic                    acc_busy,
  input wire logic                    acc_done,
  input wire logic [15:0]             acc_vector,
  input wire logic [15:0]             acc_sp,
  input wire ilpc_pkg::ilpc_stk_t     stk,
  input wire logic                    trap_reset_req,
  input wire logic                    wdog_reset_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // three stack writes, descending from the stack pointer
  sequence s_push;
    stk.we && stk.addr == cpu_sp ##1 stk.we && stk.addr == cpu_sp - 16'h1
    ##1 stk.we && stk.addr == cpu_sp - 16'h2 ##1 !stk.we;
  endsequence
  property p_accept;
    instr_boundary && irq_pending && !acc_busy |=> acc_busy;
  endproperty
  a_accept: assert property (p_accept) else $error("boundary not accepted");
  property p_push;
    $rose(acc_busy) |=> s_push;
  endproperty
  a_push: assert property (p_push) else $error("bad stack pushes");
  property p_done;
    $rose(acc_busy) |-> ##31 acc_done && !acc_busy;
  endproperty
  a_done: assert property (p_done) else $error("acceptance length wrong");
  property p_sp;
    acc_done |-> acc_sp == cpu_sp - 16'h3;
  endproperty
  a_sp: assert property (p_sp) else $error("stack pointer not lowered by three");
  property p_soft;
    instr_boundary && !acc_busy && (software_trap_source || bad_opcode_source) |=> acc_vector == 16'hfffc;
  endproperty
  a_soft: assert property (p_soft) else $error("software vector wrong");
  property p_trap;
    trap_req && trap_output_select |=> trap_reset_req;
  endproperty
  a_trap: assert property (p_trap) else $error("trap reset missing");
  property p_wdog;
    wdog_req && watchdog_output_select |=> wdog_reset_req;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog reset missing");
  property p_rdata;
    !sfr_req.rd |=> $stable(sfr_rdata);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved");
endmodule : ilpc_ctrl_assertions
bind ilpc_ctrl ilpc_ctrl_assertions i_chk (.sys_clk, .nrst, .sfr_req, .sfr_rdata, .trap_req, .wdog_req,
  .software_trap_source, .bad_opcode_source, .trap_output_select, .watchdog_output_select, .instr_boundary,
  .irq_pending, .cpu_sp, .acc_busy, .acc_done, .acc_vector, .acc_sp, .stk, .trap_reset_req, .wdog_reset_req);

// ==== tb/interrupt_latch_priority_ctrl_bench.sv ====
// self-checking bench for the interrupt latch controller
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module interrupt_latch_priority_ctrl_bench;
  import ilpc_pkg::*;
  // stimulus and observed signals
  logic          sys_clk, nrst, step, ret, trap_req, wdog_req, ext_pin_zero_gate;
  logic          software_trap_source, bad_opcode_source, trap_output_select, watchdog_output_select;
  logic          instr_boundary, reti_strobe, reti_gie, irq_pending, acc_busy, acc_done;
  logic          trap_reset_req, wdog_reset_req;
  logic [19:0]   maskable_req;
  logic [15:0]   cpu_pc, cpu_sp, acc_vector, acc_sp;
  logic [7:0]    cpu_psw, sfr_rdata;
  ilpc_sfr_req_t sfr_req;
  ilpc_stk_t     stk;
  int            fails = 0, checks = 0;
  ilpc_ctrl i_dut (.sys_clk, .nrst, .sfr_req, .sfr_rdata, .trap_req, .wdog_req, .maskable_req,
    .software_trap_source, .bad_opcode_source, .ext_pin_zero_gate, .trap_output_select, .watchdog_output_select,
    .instr_boundary, .cpu_pc, .cpu_psw, .cpu_sp, .reti_strobe, .reti_gie, .irq_pending, .acc_busy, .acc_done,
    .acc_vector, .acc_sp, .stk, .trap_reset_req, .wdog_reset_req);
  ilpc_cpu_model i_cpu (.sys_clk, .step, .ret, .instr_boundary, .cpu_pc, .cpu_psw, .cpu_sp, .reti_strobe,
    .reti_gie);
  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test
  // one byte write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) sfr_req <= '{1'b0, 1'b1, a, d};
    @(posedge sys_clk) sfr_req <= '0;
  endtask : wr
  // one byte read, compared with e
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk) sfr_req <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge sys_clk) sfr_req <= '0;
    @(negedge sys_clk) `CHK(sfr_rdata, e)
  endtask : rd
  // one-cycle hardware request pulses
  task automatic pulse(input logic t, input logic w, input logic [19:0] m);
    @(posedge sys_clk) {trap_req, wdog_req, maskable_req} <= {t, w, m};
    @(posedge sys_clk) {trap_req, wdog_req, maskable_req} <= '0;
  endtask : pulse
  // one boundary, wait for completion, judge vector, stack pointer and pushed bytes
  task automatic accept(input logic [15:0] v, input logic ie);
    int          n;
    logic [23:0] pushed;
    @(posedge sys_clk) step <= 1'b1;
    @(posedge sys_clk) step <= 1'b0;
    n = 0;
    pushed = 24'h000000;
    do
    begin
      @(negedge sys_clk) n++;
      if (stk.we === 1'b1)
        pushed = {pushed[15:0], stk.data};
    end
    while (acc_done !== 1'b1 && n < 40);
    `CHK(acc_done, 1'b1)
    `CHK(acc_vector, v)
    `CHK(acc_sp, cpu_sp - 16'h3)
    `CHK(pushed, {cpu_psw[7:1], ie, cpu_pc})
  endtask : accept
  // selects high: events become reset requests, no latch
  task automatic t_rstreq;
    pulse(1'b1, 1'b1, 20'h00000);
    @(negedge sys_clk) `CHK({trap_reset_req, wdog_reset_req}, 2'b11)
    rd(8'h3c, 8'h00);
    @(posedge sys_clk) {trap_output_select, watchdog_output_select} <= 2'b00;
  endtask : t_rstreq
  // set, poll, clear by zero, refuse set by one
  task automatic t_latch;
    pulse(1'b1, 1'b1, 20'hfffff);
    rd(8'h3c, 8'hfc);
    rd(8'h3d, 8'hff);
    rd(8'h2e, 8'hff);
    wr(8'h3c, 8'h0c); // zero write clearing bits 7:4, keeping trap and watchdog at one
    rd(8'h3c, 8'h0c);
    wr(8'h3d, 8'h00);
    wr(8'h3d, 8'hff);
    rd(8'h3d, 8'h00);
    wr(8'h2e, 8'h00);
    rd(8'h2e, 8'h00);
    rd(8'h3e, 8'h00);
  endtask : t_latch
  // non-maskable sources with everything disabled
  task automatic t_nmi;
    `CHK(irq_pending, 1'b1)
    accept(16'hfffa, 1'b0);
    accept(16'hfff8, 1'b0);
    rd(8'h3c, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge sys_clk) {software_trap_source, bad_opcode_source} <= 2'(1 << i);
      accept(16'hfffc, 1'b0);
      @(posedge sys_clk) {software_trap_source, bad_opcode_source} <= 2'b00;
    end
  endtask : t_nmi
  // enable gating, then every maskable vector in turn
  task automatic t_mask;
    wr(8'h3a, 8'hf0); // global enable off before edits
    wr(8'h3b, 8'hff);
    wr(8'h2c, 8'hff);
    pulse(1'b0, 1'b0, 20'h00001);
    @(negedge sys_clk) `CHK(irq_pending, 1'b0)
    wr(8'h3a, 8'hf1);
    @(negedge sys_clk) `CHK(irq_pending, 1'b0)
    @(posedge sys_clk) ext_pin_zero_gate <= 1'b1;
    @(negedge sys_clk) `CHK(irq_pending, 1'b1)
    accept(16'hfff6, 1'b1);
    rd(8'h3a, 8'hf0);
    for (int k = 1; k < 20; k++)
    begin
      pulse(1'b0, 1'b0, 20'(1) << k);
      wr(8'h3a, 8'hf1);
      accept(k < 12 ? 16'hfff6 - 16'(2 * k) : 16'hffbe - 16'(2 * (k - 12)), 1'b1);
    end
  endtask : t_mask
  // two maskable requests at once: lower index first
  task automatic t_prio;
    pulse(1'b0, 1'b0, 20'h20008);
    wr(8'h3a, 8'hf1);
    accept(16'hfff0, 1'b1);
    wr(8'h3a, 8'hf1);
    accept(16'hffb4, 1'b1);
  endtask : t_prio
  // converter request during a lower acceptance is lost; return restores enable
  task automatic t_conv;
    pulse(1'b0, 1'b0, 20'h01000);
    wr(8'h3a, 8'hf1);
    fork
      accept(16'hffbe, 1'b1);
      begin
        repeat (2) @(posedge sys_clk);
        maskable_req <= 20'h00800;
        @(posedge sys_clk) maskable_req <= '0;
      end
    join
    rd(8'h3d, 8'h00);
    rd(8'h3a, 8'hf0);
    pulse(1'b0, 1'b0, 20'h00800);
    rd(8'h3d, 8'h80);
    wr(8'h3d, 8'h00);
    @(posedge sys_clk) ret <= 1'b1;
    @(posedge sys_clk) ret <= 1'b0;
    rd(8'h3a, 8'hf1);
  endtask : t_conv
  // free-running clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // watchdog on a hung run
  initial
  begin
    #200000;
    fails++;
    stop_test();
  end
  // reset, then the scenarios
  initial
  begin
    {nrst, step, ret, trap_req, wdog_req, ext_pin_zero_gate, software_trap_source, bad_opcode_source} = '0;
    {trap_output_select, watchdog_output_select} = 2'b11;
    maskable_req = '0;
    sfr_req = '0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(8'h3c, 8'h00);
    rd(8'h3d, 8'h00);
    rd(8'h3a, 8'h00);
    t_rstreq();
    t_latch();
    t_nmi();
    t_mask();
    t_prio();
    t_conv();
    stop_test();
  end
endmodule : interrupt_latch_priority_ctrl_bench
